// [pkg/sgsw_defs.svh]
// constants for the servo gain switch and speed feedback block
// included by the package and the gain switch design file; definitions only
`ifndef SGSW_DEFS_SVH
`define SGSW_DEFS_SVH
`define SGSW_SEL_FIXED_A 4'h0
`define SGSW_SEL_EXT 4'h1
`define SGSW_SEL_TORQUE 4'h2
`define SGSW_SEL_DEV 4'h3
`define SGSW_SEL_ACCEL 4'h4
`define SGSW_SEL_SPDREF 4'h5
`define SGSW_SEL_POSREF 4'h6
`define SGSW_SEL_SPEED 4'h7
`define SGSW_SEL_BOTH 4'h8
`define SGSW_SEL_FIXED_B 4'h9
`define SGSW_SEL_POSDONE 4'ha
`define SGSW_FB_ENCODER 1'h0
`define SGSW_FB_OBSERVER 1'h1
`define SGSW_SPEED_THR_MAX 16'h07d0
`define SGSW_CLK_NS 100
`define SGSW_TICK_NS 100000
`define SGSW_TICK_CYC (`SGSW_TICK_NS / `SGSW_CLK_NS)
`define SGSW_TICK_CNT_MAX 10'h3e7
`define SGSW_FILT_SHIFT_MAX 5'h0f
`define SGSW_OBS_SHIFT 5'h0a
`endif

// [pkg/sgsw_pkg.sv]
// types for the servo gain switch and speed feedback block
// used by the gain switch design file and the test files
`include "sgsw_defs.svh"
package sgsw_pkg;
   typedef logic [3:0] sgsw_sel_t;
   typedef logic [15:0] sgsw_val_t;
   typedef logic signed [31:0] sgsw_pos_t;
   typedef logic signed [15:0] sgsw_spd_t;
   typedef enum logic [1:0]
   {
      SGSW_ST_A = 2'b00,
      SGSW_ST_WAIT_B = 2'b01,
      SGSW_ST_B = 2'b10,
      SGSW_ST_WAIT_A = 2'b11
   } sgsw_state_e;
endpackage : sgsw_pkg

// [design/sgsw_hyst_cmp.sv]
// threshold comparator with hysteresis for one monitored quantity
// assumes magnitude inputs and settings all in the same units
`timescale 1ns/100ps
`default_nettype none
module sgsw_hyst_cmp
(
   input wire logic i_core_clk, // core clock
   input wire logic i_arst_n, // async reset
   input wire logic [16:0] i_value, // magnitude under test
   input wire logic [15:0] i_threshold, // switch level
   input wire logic [15:0] i_hysteresis, // band width
   output logic o_above // condition met, held
);
   logic above_reg;
   logic above_next;
   logic [16:0] upper;
   // rise above threshold plus band, fall at or below threshold
   always_comb
   begin
      upper = {1'b0, i_threshold} + {1'b0, i_hysteresis};
      above_next = above_reg;
      if (i_value > upper)
      begin
         above_next = 1'b1;
      end
      else if (i_value <= {1'b0, i_threshold})
      begin
         above_next = 1'b0;
      end
   end
   // held flag keeps small ripple near the level from toggling
   always_ff @(posedge i_core_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         above_reg <= 1'b0;
      else
         above_reg <= above_next;
   end
   assign o_above = above_reg;
   hyst_set_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (i_value > {1'b0, i_threshold} + {1'b0, i_hysteresis}) |=> above_reg)
      else $error("hysteresis comparator failed to set");
endmodule : sgsw_hyst_cmp
`default_nettype wire

// [design/sgsw_gain_switch.sv]
// servo gain group selection and speed feedback source choice
// assumes all inputs are synchronous to i_core_clk; settings may
// change at any time, the two selectors are sampled at reset only
// Summary of operation
// R1: hold two gain groups, feed one
// R2: start on first group, switch on condition
// R3: selector 0 keeps first group
// R4: 1 uses external input, 10 positioning done
// R5: modes 2..7 compare quantity with threshold
// R6: map each mode to its quantity and threshold
// R7: hysteresis around thresholds prevents toggling
// R8: mode 8 position above threshold plus band
// R9: mode 8 also needs speed above threshold
// R10: selector 9 keeps second group
// R11: delay, thresholds, ramp, band apply immediately
// R12: encoder speed from position difference per tick
// R13: feedback selector 0 encoder, 1 observer, restart
// R14: observer always runs, output for monitoring
// R15: encoder speed low-pass by filter time
// R16: observer gain sets observer bandwidth
// R17: speed threshold in rpm, capped at 2000
// R18: delay group change, cancel on reversal
// R19: position gain ramps linearly over ramp time
`timescale 1ns/100ps
`default_nettype none
`include "sgsw_defs.svh"
module sgsw_gain_switch
(
   input wire logic i_core_clk, // 10 MHz core clock
   input wire logic i_arst_n, // async reset, low active
   input wire sgsw_pkg::sgsw_sel_t i_gain_switch_select, // mode
   input wire sgsw_pkg::sgsw_val_t i_gain_switch_delay, // 0.1 ms
   input wire sgsw_pkg::sgsw_val_t i_gain_switch_threshold, // general
   input wire sgsw_pkg::sgsw_val_t i_gain_switch_speed_threshold, // rpm
   input wire sgsw_pkg::sgsw_val_t i_position_gain_ramp_time, // 0.1 ms
   input wire sgsw_pkg::sgsw_val_t i_gain_switch_hysteresis, // band
   input wire sgsw_pkg::sgsw_val_t i_torque_ref_threshold, // mode 2
   input wire sgsw_pkg::sgsw_val_t i_deviation_threshold, // mode 3
   input wire sgsw_pkg::sgsw_val_t i_accel_threshold, // mode 4
   input wire sgsw_pkg::sgsw_val_t i_speed_ref_threshold, // mode 5
   input wire logic i_gain_select_ext, // external select, high
   input wire logic i_position_done, // positioning completed
   input wire sgsw_pkg::sgsw_spd_t i_torque_ref, // torque reference
   input wire sgsw_pkg::sgsw_spd_t i_deviation, // deviation counter
   input wire sgsw_pkg::sgsw_spd_t i_accel, // acceleration
   input wire sgsw_pkg::sgsw_spd_t i_speed_ref, // speed reference
   input wire sgsw_pkg::sgsw_spd_t i_position_ref, // position ref rate
   input wire sgsw_pkg::sgsw_pos_t i_encoder_pos, // encoder position
   input wire sgsw_pkg::sgsw_spd_t i_torque_est, // torque as accel
   input wire logic i_feedback_source_select, // 0 enc, 1 observer
   input wire sgsw_pkg::sgsw_val_t i_observer_gain, // Hz
   input wire sgsw_pkg::sgsw_val_t i_encoder_speed_filter_time, // shift
   input wire sgsw_pkg::sgsw_val_t i_speed_gain_a, // group 1
   input wire sgsw_pkg::sgsw_val_t i_speed_integral_a, // group 1
   input wire sgsw_pkg::sgsw_val_t i_position_gain_a, // group 1
   input wire sgsw_pkg::sgsw_val_t i_torque_filter_a, // group 1
   input wire sgsw_pkg::sgsw_val_t i_speed_gain_b, // group 2
   input wire sgsw_pkg::sgsw_val_t i_speed_integral_b, // group 2
   input wire sgsw_pkg::sgsw_val_t i_position_gain_b, // group 2
   input wire sgsw_pkg::sgsw_val_t i_torque_filter_b, // group 2
   output logic o_group_b, // second group active
   output sgsw_pkg::sgsw_val_t o_speed_gain, // active speed gain
   output sgsw_pkg::sgsw_val_t o_speed_integral, // active integral
   output sgsw_pkg::sgsw_val_t o_position_gain, // ramped pos gain
   output sgsw_pkg::sgsw_val_t o_torque_filter, // active filter
   output sgsw_pkg::sgsw_spd_t o_encoder_speed, // filtered enc speed
   output sgsw_pkg::sgsw_spd_t o_observer_speed, // observer estimate
   output sgsw_pkg::sgsw_spd_t o_feedback_speed, // to speed loop
   output logic o_control_tick // one-cycle control tick
);
   import sgsw_pkg::*;

   // magnitude of a signed quantity, one bit wider
   function automatic logic [16:0] mag(input sgsw_spd_t v);
      mag = v[15] ? 17'(-{v[15], v}) : {1'b0, v};
   endfunction : mag

   sgsw_sel_t mode_reg;
   logic fb_sel_reg;
   logic sampled_reg;
   logic [9:0] tick_cnt_reg;
   logic tick_reg;
   sgsw_state_e state_reg;
   sgsw_state_e state_next;
   logic [15:0] delay_cnt_reg;
   logic [15:0] ramp_cnt_reg;
   sgsw_val_t pos_gain_reg;
   sgsw_val_t ramp_from_reg;
   sgsw_pos_t enc_prev_reg;
   logic signed [31:0] enc_filt_reg;
   logic signed [31:0] obs_reg;
   sgsw_spd_t fb_reg;
   logic cond_torque, cond_dev, cond_accel, cond_spdref;
   logic cond_posref, cond_speed;
   logic condition;
   logic [15:0] speed_thr;
   logic signed [16:0] enc_raw;
   sgsw_spd_t enc_speed;
   logic [4:0] filt_shift;

   // selectors take effect only after restart: caught once after release
   always_ff @(posedge i_core_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         mode_reg <= `SGSW_SEL_FIXED_A;
         fb_sel_reg <= `SGSW_FB_ENCODER;
         sampled_reg <= 1'b0;
      end
      else if (!sampled_reg)
      begin
         mode_reg <= i_gain_switch_select;
         fb_sel_reg <= i_feedback_source_select; // [R13]
         sampled_reg <= 1'b1;
      end
   end

   // 0.1 ms control period tick, the unit of delay and ramp counts
   always_ff @(posedge i_core_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         tick_cnt_reg <= 10'h000;
         tick_reg <= 1'b0;
      end
      else if (tick_cnt_reg == `SGSW_TICK_CNT_MAX)
      begin
         tick_cnt_reg <= 10'h000;
         tick_reg <= 1'b1;
      end
      else
      begin
         tick_cnt_reg <= tick_cnt_reg + 10'h001;
         tick_reg <= 1'b0;
      end
   end
   assign o_control_tick = tick_reg;

   // speed threshold clipped to its accepted rpm range
   assign speed_thr = (i_gain_switch_speed_threshold > `SGSW_SPEED_THR_MAX)
      ? `SGSW_SPEED_THR_MAX : i_gain_switch_speed_threshold; // [R17]

   // one hysteresis comparator per monitored quantity
   sgsw_hyst_cmp u_cmp_torque (.i_core_clk(i_core_clk),
      .i_arst_n(i_arst_n), .i_value(mag(i_torque_ref)),
      .i_threshold(i_torque_ref_threshold),
      .i_hysteresis(i_gain_switch_hysteresis), .o_above(cond_torque)); // [R7]
   sgsw_hyst_cmp u_cmp_dev (.i_core_clk(i_core_clk),
      .i_arst_n(i_arst_n), .i_value(mag(i_deviation)),
      .i_threshold(i_deviation_threshold),
      .i_hysteresis(i_gain_switch_hysteresis), .o_above(cond_dev));
   sgsw_hyst_cmp u_cmp_accel (.i_core_clk(i_core_clk),
      .i_arst_n(i_arst_n), .i_value(mag(i_accel)),
      .i_threshold(i_accel_threshold),
      .i_hysteresis(i_gain_switch_hysteresis), .o_above(cond_accel));
   sgsw_hyst_cmp u_cmp_spdref (.i_core_clk(i_core_clk),
      .i_arst_n(i_arst_n), .i_value(mag(i_speed_ref)),
      .i_threshold(i_speed_ref_threshold),
      .i_hysteresis(i_gain_switch_hysteresis), .o_above(cond_spdref));
   sgsw_hyst_cmp u_cmp_posref (.i_core_clk(i_core_clk),
      .i_arst_n(i_arst_n), .i_value(mag(i_position_ref)),
      .i_threshold(i_gain_switch_threshold),
      .i_hysteresis(i_gain_switch_hysteresis), .o_above(cond_posref)); // [R8]
   sgsw_hyst_cmp u_cmp_speed (.i_core_clk(i_core_clk),
      .i_arst_n(i_arst_n), .i_value(mag(fb_reg)),
      .i_threshold(speed_thr),
      .i_hysteresis(i_gain_switch_hysteresis), .o_above(cond_speed));

   // switching condition chosen by the mode
   always_comb
   begin
      unique case (mode_reg)
         `SGSW_SEL_FIXED_A: condition = 1'b0; // [R3]
         `SGSW_SEL_EXT: condition = i_gain_select_ext; // [R4]
         `SGSW_SEL_TORQUE: condition = cond_torque; // [R5] [R6]
         `SGSW_SEL_DEV: condition = cond_dev; // [R6]
         `SGSW_SEL_ACCEL: condition = cond_accel; // [R6]
         `SGSW_SEL_SPDREF: condition = cond_spdref; // [R6]
         `SGSW_SEL_POSREF: condition = cond_posref; // [R6]
         `SGSW_SEL_SPEED: condition = cond_speed; // [R6]
         `SGSW_SEL_BOTH: condition = cond_posref & cond_speed; // [R9]
         `SGSW_SEL_FIXED_B: condition = 1'b1; // [R10]
         `SGSW_SEL_POSDONE: condition = i_position_done; // [R4]
         default: condition = 1'b0; // codes 11..15 fall back to group 1
      endcase
   end

   // group state: wait the delay, abandon the change if condition reverts
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         SGSW_ST_A:
            if (condition)
               state_next = SGSW_ST_WAIT_B;
         SGSW_ST_WAIT_B:
            if (!condition)
               state_next = SGSW_ST_A; // [R18]
            else if (delay_cnt_reg >= i_gain_switch_delay)
               state_next = SGSW_ST_B; // [R11]
         SGSW_ST_B:
            if (!condition)
               state_next = SGSW_ST_WAIT_A;
         SGSW_ST_WAIT_A:
            if (condition)
               state_next = SGSW_ST_B; // [R18]
            else if (delay_cnt_reg >= i_gain_switch_delay)
               state_next = SGSW_ST_A;
      endcase
   end

   // start-up always on the first group
   always_ff @(posedge i_core_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         state_reg <= SGSW_ST_A; // [R2]
      else
         state_reg <= state_next;
   end

   // delay counter in control ticks, restarted on every state change
   always_ff @(posedge i_core_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         delay_cnt_reg <= 16'h0000;
      else if (state_next != state_reg)
         delay_cnt_reg <= 16'h0000;
      else if (tick_reg && delay_cnt_reg != 16'hffff)
         delay_cnt_reg <= delay_cnt_reg + 16'h0001;
   end

   assign o_group_b = (state_reg == SGSW_ST_B)
      || (state_reg == SGSW_ST_WAIT_A);

   // data outputs registered from the active group
   always_ff @(posedge i_core_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         o_speed_gain <= 16'h0000;
         o_speed_integral <= 16'h0000;
         o_torque_filter <= 16'h0000;
      end
      else
      begin
         o_speed_gain <= o_group_b ? i_speed_gain_b : i_speed_gain_a; // [R1]
         o_speed_integral <= o_group_b ? i_speed_integral_b
            : i_speed_integral_a;
         o_torque_filter <= o_group_b ? i_torque_filter_b : i_torque_filter_a;
      end
   end

   // linear position gain ramp; zero ramp time steps at once
   always_ff @(posedge i_core_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         ramp_cnt_reg <= 16'h0000;
         ramp_from_reg <= 16'h0000;
         pos_gain_reg <= 16'h0000;
      end
      else
      begin
         if (o_group_b != (state_next == SGSW_ST_B
            || state_next == SGSW_ST_WAIT_A))
         begin
            ramp_cnt_reg <= 16'h0000;
            ramp_from_reg <= pos_gain_reg;
         end
         else if (tick_reg && ramp_cnt_reg < i_position_gain_ramp_time)
            ramp_cnt_reg <= ramp_cnt_reg + 16'h0001;
         if (ramp_cnt_reg >= i_position_gain_ramp_time)
            pos_gain_reg <= o_group_b ? i_position_gain_b : i_position_gain_a;
         else
            pos_gain_reg <= 16'(32'($signed({1'b0, ramp_from_reg}))
               + 32'(($signed({1'b0, (o_group_b ? i_position_gain_b
               : i_position_gain_a)}) - $signed({1'b0, ramp_from_reg}))
               * $signed({1'b0, ramp_cnt_reg})
               / $signed({1'b0, i_position_gain_ramp_time}))); // [R19]
      end
   end
   assign o_position_gain = pos_gain_reg;

   // encoder speed: position difference per tick
   assign enc_raw = 17'(i_encoder_pos - enc_prev_reg); // [R12]
   assign filt_shift = (i_encoder_speed_filter_time > 16'(`SGSW_FILT_SHIFT_MAX))
      ? `SGSW_FILT_SHIFT_MAX : i_encoder_speed_filter_time[4:0];
   assign enc_speed = 16'(enc_filt_reg >>> 16);

   // first-order low-pass: larger shift is smoother but lags more
   always_ff @(posedge i_core_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         enc_prev_reg <= 32'h00000000;
         enc_filt_reg <= 32'h00000000;
      end
      else if (tick_reg)
      begin
         enc_prev_reg <= i_encoder_pos;
         enc_filt_reg <= enc_filt_reg + (($signed({enc_raw[15:0], 16'h0000})
            - enc_filt_reg) >>> filt_shift); // [R15]
      end
   end

   // observer: model integrates torque, corrected by gain-weighted error
   always_ff @(posedge i_core_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         obs_reg <= 32'h00000000;
      else if (tick_reg)
         obs_reg <= obs_reg + $signed({{16{i_torque_est[15]}}, i_torque_est})
            + ((($signed({{16{enc_raw[15]}}, enc_raw[15:0]}) <<< 16)
            - obs_reg) >>> `SGSW_OBS_SHIFT)
            * $signed({16'h0000, i_observer_gain}) / 32'sd1000; // [R14] [R16]
   end
   assign o_observer_speed = 16'(obs_reg >>> 16);
   assign o_encoder_speed = enc_speed;

   // feedback source mux, registered
   always_ff @(posedge i_core_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         fb_reg <= 16'h0000;
      else
         fb_reg <= (fb_sel_reg == `SGSW_FB_OBSERVER) ? o_observer_speed
            : enc_speed; // [R13]
   end
   assign o_feedback_speed = fb_reg;

   fixed_a_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (mode_reg == `SGSW_SEL_FIXED_A) |-> !o_group_b) // [R3]
      else $error("group 2 active in fixed first mode");
   fixed_b_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (sampled_reg && mode_reg == `SGSW_SEL_FIXED_B && state_reg == SGSW_ST_A
      && i_gain_switch_delay == 16'h0000) |-> ##2 o_group_b) // [R10]
      else $error("fixed second mode did not switch");
   cancel_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (state_reg == SGSW_ST_WAIT_B && !condition) |=> state_reg == SGSW_ST_A)
      else $error("reverted condition did not cancel switch"); // [R18]
   both_cond_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (mode_reg == `SGSW_SEL_BOTH && !(cond_posref && cond_speed)
      && state_reg == SGSW_ST_A) |=> state_reg == SGSW_ST_A) // [R9]
      else $error("mode 8 left group 1 without both conditions");
   ext_sel_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (mode_reg == `SGSW_SEL_EXT && state_reg == SGSW_ST_A
      && i_gain_select_ext) |=> state_reg == SGSW_ST_WAIT_B) // [R4]
      else $error("external select not followed");
   gain_out_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      o_group_b |=> o_speed_gain == $past(i_speed_gain_b)) // [R1]
      else $error("speed gain not from group 2");
   fb_src_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (fb_sel_reg == `SGSW_FB_ENCODER) |=> fb_reg == $past(enc_speed))
      else $error("feedback not from encoder"); // [R13]
   spd_cap_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      speed_thr <= `SGSW_SPEED_THR_MAX && (speed_thr
      == i_gain_switch_speed_threshold
      || i_gain_switch_speed_threshold > `SGSW_SPEED_THR_MAX)) // [R17]
      else $error("speed threshold above range");
   delay_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (state_reg == SGSW_ST_WAIT_B && condition
      && delay_cnt_reg < i_gain_switch_delay) |=> state_reg == SGSW_ST_WAIT_B)
      else $error("switch before delay elapsed"); // [R11] [R18]
endmodule : sgsw_gain_switch
`default_nettype wire

// [test/sgsw_motion_model.sv]
// motor encoder and host select line at the block's far side
// assumes the bench drives its controls just after rising edges
`timescale 1ns/100ps
`default_nettype none
module sgsw_motion_model
(
   input wire logic i_core_clk, // core clock
   input wire logic i_arst_n, // async reset, low
   input wire sgsw_pkg::sgsw_spd_t i_step, // counts per 0.1 ms
   input wire logic i_ext_req, // wanted select level
   output var sgsw_pkg::sgsw_pos_t o_encoder_pos, // shaft position
   output logic o_gain_select_ext // select line to block
);
   import sgsw_pkg::*;
   int cyc;
   // shaft advances once per 0.1 ms, on the same edge as the block tick
   always_ff @(posedge i_core_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         cyc <= 0;
         o_encoder_pos <= 32'sh0000_0000;
      end
      else if (cyc == 999)
      begin
         cyc <= 0;
         o_encoder_pos <= o_encoder_pos + 32'(i_step);
      end
      else
         cyc <= cyc + 1;
   end
   // host output is registered, so the block sees it one cycle late
   always_ff @(posedge i_core_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         o_gain_select_ext <= 1'b0;
      else
         o_gain_select_ext <= i_ext_req;
   end
endmodule : sgsw_motion_model
`default_nettype wire

// [test/sgsw_gain_switch_tb.sv]
// self-checking bench for gain group switching and speed feedback
// assumes one 10 MHz clock and the motion model as far side
`timescale 1ns/100ps
`default_nettype none
module sgsw_gain_switch_tb;
   import sgsw_pkg::*;
   logic clk, rst_n, ext_req, pos_done, fb_sel, grp_b, tick, ext;
   sgsw_sel_t sel;
   sgsw_val_t dly, thr, sthr, ramp, hyst, qthr, filt, ogain;
   sgsw_val_t sg, si, pg, tf;
   sgsw_val_t ga[4], gb[4];
   sgsw_spd_t q[5], step, test, enc_spd, obs_spd, fb_spd;
   sgsw_pos_t pos;
   int miscompares, n_compared, k;
   sgsw_gain_switch u_sgsw_gain_switch
   (
      .i_core_clk(clk), .i_arst_n(rst_n), .i_gain_switch_select(sel),
      .i_gain_switch_delay(dly), .i_gain_switch_threshold(thr),
      .i_gain_switch_speed_threshold(sthr),
      .i_position_gain_ramp_time(ramp), .i_gain_switch_hysteresis(hyst),
      .i_torque_ref_threshold(qthr), .i_deviation_threshold(qthr),
      .i_accel_threshold(qthr), .i_speed_ref_threshold(qthr),
      .i_gain_select_ext(ext), .i_position_done(pos_done),
      .i_torque_ref(q[0]), .i_deviation(q[1]), .i_accel(q[2]),
      .i_speed_ref(q[3]), .i_position_ref(q[4]), .i_encoder_pos(pos),
      .i_torque_est(test), .i_feedback_source_select(fb_sel),
      .i_observer_gain(ogain), .i_encoder_speed_filter_time(filt),
      .i_speed_gain_a(ga[0]), .i_speed_integral_a(ga[1]),
      .i_position_gain_a(ga[2]), .i_torque_filter_a(ga[3]),
      .i_speed_gain_b(gb[0]), .i_speed_integral_b(gb[1]),
      .i_position_gain_b(gb[2]), .i_torque_filter_b(gb[3]),
      .o_group_b(grp_b), .o_speed_gain(sg), .o_speed_integral(si),
      .o_position_gain(pg), .o_torque_filter(tf),
      .o_encoder_speed(enc_spd), .o_observer_speed(obs_spd),
      .o_feedback_speed(fb_spd), .o_control_tick(tick)
   );
   sgsw_motion_model u_sgsw_motion_model
   (
      .i_core_clk(clk), .i_arst_n(rst_n), .i_step(step),
      .i_ext_req(ext_req), .o_encoder_pos(pos), .o_gain_select_ext(ext)
   );
   // free-running 100 ns clock
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // inputs move 10 ns after the edge, well clear of sampling
   task automatic step_c(input int n);
      repeat (n) @(posedge clk);
      #10;
   endtask : step_c
   task automatic summarize;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : summarize
   task automatic chk(input logic [15:0] got, exp, input string m);
      n_compared++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   // bounded wait for the group flag; running out ends the run
   task automatic wait_b(input logic e, input int n);
      k = 0;
      while (grp_b !== e && k < n)
      begin
         step_c(1);
         k++;
      end
      chk(16'(grp_b), 16'(e), "group flag");
      if (grp_b !== e)
         summarize();
   endtask : wait_b
   task automatic hold(input logic e, input int n);
      repeat (n)
      begin
         step_c(1);
         chk(16'(grp_b), 16'(e), "group held");
      end
   endtask : hold
   task automatic gains(input logic b);
      step_c(2);
      chk(sg, b ? gb[0] : ga[0], "speed gain");
      chk(si, b ? gb[1] : ga[1], "integral");
      chk(tf, b ? gb[3] : ga[3], "torque filter");
   endtask : gains
   // selectors are taken at reset release, so each mode needs a reset
   task automatic boot(input sgsw_sel_t m, input logic f);
      if (n_compared > 0)
         $display("end of test for mode %0d", sel);
      rst_n = 1'b0;
      sel = m;
      fb_sel = f;
      foreach (q[i]) q[i] = 16'sh0000;
      foreach (ga[i]) ga[i] = 16'(i + 1);
      foreach (gb[i]) gb[i] = 16'(i + 16'h0040);
      {ext_req, pos_done, step, test} = '0;
      {dly, thr, sthr, ramp, hyst} = {16'h0, 16'h64, 16'h14, 16'h4, 16'h14};
      {qthr, filt, ogain} = {16'h0064, 16'h0000, 16'h00c8};
      step_c(2);
      rst_n = 1'b1;
      step_c(2);
   endtask : boot
   initial
   begin
      miscompares = 0;
      n_compared = 0;
      boot(4'h0, 1'b0);
      {ext_req, pos_done} = 2'b11;
      foreach (q[i]) q[i] = 16'sh01f4;
      hold(1'b0, 30);
      gains(1'b0);
      boot(4'h9, 1'b0);
      wait_b(1'b1, 10);
      gains(1'b1);
      boot(4'h1, 1'b0);
      ext_req = 1'b1;
      wait_b(1'b1, 10);
      gains(1'b1);
      n_compared++;
      if (pg === gb[2])
      begin
         miscompares++;
         $display("BAD %0t position gain stepped", $time);
      end
      step_c(6000);
      chk(pg, gb[2], "ramp end");
      ext_req = 1'b0;
      wait_b(1'b0, 10);
      dly = 16'h0003;
      ext_req = 1'b1;
      hold(1'b0, 1500);
      ext_req = 1'b0;
      hold(1'b0, 5000);
      ext_req = 1'b1;
      wait_b(1'b1, 5000);
      boot(4'ha, 1'b0);
      pos_done = 1'b1;
      wait_b(1'b1, 10);
      pos_done = 1'b0;
      wait_b(1'b0, 10);
      for (int m = 2; m <= 6; m++)
      begin
         boot(4'(m), 1'b0);
         foreach (q[i]) q[i] = 16'sh01f4;
         q[m-2] = 16'sh0000;
         hold(1'b0, 20);
         q[m-2] = -16'sh0082;
         wait_b(1'b1, 10);
         q[m-2] = 16'sh006e;
         hold(1'b1, 20);
         q[m-2] = 16'sh005a;
         wait_b(1'b0, 10);
         q[m-2] = 16'sh006e;
         hold(1'b0, 20);
         {thr, qthr} = {16'h0032, 16'h0032};
         wait_b(1'b1, 10);
      end
      boot(4'h7, 1'b0);
      step = 16'sh0032;
      wait_b(1'b1, 5000);
      chk(enc_spd, 16'h0032, "encoder speed");
      chk(fb_spd, 16'h0032, "feedback speed");
      step = 16'sh000a;
      wait_b(1'b0, 5000);
      boot(4'h8, 1'b0);
      q[4] = 16'sh0082;
      hold(1'b0, 3000);
      // clear the held position condition so 110 starts from below
      q[4] = 16'sh0000;
      step_c(2);
      q[4] = 16'sh006e;
      step = 16'sh0032;
      hold(1'b0, 3000);
      q[4] = 16'sh0082;
      wait_b(1'b1, 10);
      step = 16'sh0000;
      wait_b(1'b0, 5000);
      boot(4'h0, 1'b1);
      step = 16'sh0032;
      step_c(5000);
      k = 0;
      while (tick !== 1'b1 && k < 1100)
      begin
         step_c(1);
         k++;
      end
      chk(16'(tick), 16'h0001, "control tick");
      if (tick !== 1'b1)
         summarize();
      step_c(10);
      chk(fb_spd, obs_spd, "observer feedback");
      // encoder speed is 50 here while the slow observer is still low
      n_compared++;
      if (fb_spd === enc_spd)
      begin
         miscompares++;
         $display("BAD %0t feedback follows encoder", $time);
      end
      $display("end of test for mode %0d", sel);
      summarize();
   end
endmodule : sgsw_gain_switch_tb
`default_nettype wire
